/* design/lss_pkg.sv */
// Shared constants for the LIN sync status block.
// Assumes a 100 MHz core clock and a synchronous LIN receive level.
package lss_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] ADDR_STATUS = 32'hffff0780;
	localparam logic [31:0] ADDR_CTL0 = 32'hffff0784;
	localparam logic [31:0] ADDR_EDGE = 32'hffff0788;
	localparam logic [31:0] ADDR_SYNC_VAL = 32'hffff078c;
	localparam logic [31:0] ADDR_BRK_VAL = 32'hffff0790;
	localparam logic [31:0] ADDR_SYNC_CMP = 32'hffff0794;
	localparam logic [31:0] ADDR_BRK_CMP = 32'hffff0798;
	localparam logic [31:0] ADDR_IRQ_STAT = 32'hffff079c;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'hffff07a0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int ST_BRK = 0;
	localparam int ST_START = 1;
	localparam int ST_STOP = 2;
	localparam int ST_CMP = 3;
	localparam int ST_BRK_ERR = 4;
	localparam int ST_RST_DONE = 5;
	localparam int ST_RISE = 6;
	localparam int ST_RSVD = 7;
	localparam int CTL_EN = 0;
	localparam int CTL_URST = 1;
	localparam int CTL_BSM = 2;
	localparam int CTL_RISE_DIS = 12;
	localparam int EDGE_START_LSB = 0;
	localparam int EDGE_STOP_LSB = 4;
	localparam int EDGE_RISE = 7;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h10;
	localparam logic [15:0] CTL0_RST = 16'h0000;
	localparam logic [7:0] EDGE_RST = 8'h51;
	localparam logic [11:0] BRK_CMP_RST = 12'h000;
	localparam logic [15:0] SYNC_CMP_RST = 16'h0000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int BAUD_MIN_HZ = 1000;
	localparam int BAUD_MAX_HZ = 20000;
	localparam int CORE_CLK_HZ = 100_000_000;
	localparam int SYNC_CLK_HZ = 5_000_000;
	localparam int SYNC_DIV = CORE_CLK_HZ / SYNC_CLK_HZ;
	localparam logic [4:0] SYNC_DIV_LAST = 5'(SYNC_DIV - 1);
	localparam logic [11:0] BRK_CNT_MAX = 12'hfff;
	localparam logic [15:0] SYNC_CNT_MAX = 16'hffff;

	typedef enum logic [1:0] {
		SY_IDLE = 2'b00,
		SY_ARMED = 2'b01,
		SY_RUN = 2'b10
	} lss_sync_st_t;

endpackage : lss_pkg

/* design/lss_brk_timer.sv */
// 12-bit break timer counting low time of the LIN line.
// Assumes lp_tick is a one-cycle pulse per low power oscillator period.
module lss_brk_timer
	import lss_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Line and control
	input wire logic lin_rx,
	input wire logic lp_tick,
	input wire logic clr,
	input wire logic [11:0] brk_cmp,
	// Results
	output logic [11:0] count,
	output logic brk_hit,
	output logic brk_ovf
);

	typedef struct packed {
		logic [11:0] cnt;
		logic hit;
		logic ovf;
	} lss_brk_t;

	lss_brk_t s_r, s_nxt;
	logic [11:0] inc;

	always_comb
	begin
		s_nxt = s_r;
		inc = s_r.cnt + 12'h001;
		s_nxt.hit = 1'b0;
		s_nxt.ovf = 1'b0;
		if (clr || lin_rx)
			s_nxt.cnt = 12'h000;
		else if (lp_tick)
		begin
			s_nxt.cnt = inc;
			s_nxt.hit = (inc == brk_cmp);
			s_nxt.ovf = (s_r.cnt == BRK_CNT_MAX);
		end
	end

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;

	assign count = s_r.cnt;
	assign brk_hit = s_r.hit;
	assign brk_ovf = s_r.ovf;

endmodule : lss_brk_timer

/* design/lss_sync_timer.sv */
// 16-bit sync byte timer on a 5 MHz tick, started and stopped by edges.
// Assumes lin_rx is synchronous and brk_hit pulses once per valid break.
module lss_sync_timer
	import lss_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Line and control
	input wire logic lin_rx,
	input wire logic enable,
	input wire logic clr,
	input wire logic brk_hit,
	input wire logic edge_rise,
	input wire logic [2:0] start_sel,
	input wire logic [2:0] stop_sel,
	input wire logic [15:0] cmp_val,
	// Results
	output logic [15:0] count,
	output logic start_p,
	output logic stop_p,
	output logic cmp_p,
	output logic rise_p
);

	typedef struct packed {
		lss_sync_st_t st;
		logic rx_q;
		logic [4:0] div;
		logic [2:0] edges;
		logic [15:0] cnt;
		logic start;
		logic stop;
		logic cmp;
		logic rise;
	} lss_sync_t;

	lss_sync_t s_r, s_nxt;
	logic rise, fall, sel, tick;
	logic [2:0] e_nx;
	logic [15:0] c_nx;

	always_comb
	begin
		s_nxt = s_r;
		rise = !s_r.rx_q && lin_rx;
		fall = s_r.rx_q && !lin_rx;
		sel = edge_rise ? rise : fall;
		tick = (s_r.div == SYNC_DIV_LAST);
		e_nx = s_r.edges + 3'h1;
		c_nx = s_r.cnt + 16'h0001;
		s_nxt.rx_q = lin_rx;
		s_nxt.rise = rise;
		s_nxt.div = tick ? 5'h00 : s_r.div + 5'h01;
		s_nxt.start = 1'b0;
		s_nxt.stop = 1'b0;
		s_nxt.cmp = 1'b0;
		if (clr || !enable)
		begin
			s_nxt.st = SY_IDLE;
			s_nxt.edges = 3'h0;
			if (clr)
				s_nxt.cnt = 16'h0000;
		end
		else
		begin
			unique case (s_r.st)
				SY_IDLE:
					if (brk_hit)
					begin
						s_nxt.st = SY_ARMED;
						s_nxt.edges = 3'h0;
					end
				SY_ARMED:
					if (sel)
					begin
						s_nxt.edges = e_nx;
						if (e_nx == start_sel)
						begin
							s_nxt.st = SY_RUN;
							s_nxt.cnt = 16'h0000;
							s_nxt.start = 1'b1;
						end
					end
				SY_RUN:
				begin
					// Saturates; a 1 kBaud byte still fits
					if (tick && s_r.cnt != SYNC_CNT_MAX)
					begin
						s_nxt.cnt = c_nx;
						s_nxt.cmp = (c_nx == cmp_val);
					end
					if (sel)
					begin
						s_nxt.edges = e_nx;
						if (e_nx == stop_sel)
						begin
							s_nxt.st = SY_IDLE;
							s_nxt.stop = 1'b1;
						end
					end
				end
				default:
					s_nxt.st = SY_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			// Idle line is recessive; no false edge after reset
			s_r <= '0;
			s_r.rx_q <= 1'b1;
		end
		else
			s_r <= s_nxt;

	assign count = s_r.cnt;
	assign start_p = s_r.start;
	assign stop_p = s_r.stop;
	assign cmp_p = s_r.cmp;
	assign rise_p = s_r.rise;

endmodule : lss_sync_timer

/* design/lss_sync_status.sv */
// Status, event and register logic of the LIN sync unit, AHB-Lite slave.
// Assumes lin_rx and lp_osc_tick are synchronous to core_clk.
// What this block does
// - Slave node only, 1 to 20 kBaud
// - Break timer ticks from low power oscillator
// - Sync byte timed on derived 5 MHz tick
// - Software selects start and stop edges
// - 16-bit sync timer governed by control register
// - 8-bit read-only status, resets to zero
// - Status bit 7 reserved, reads zero
// - Bit 6 rising edge, bit-serial mode only
// - Bit 5 set when unit reset completes
// - Bit 4 break timer overflow, raises interrupt
// - Bit 3 sync timer equals compare value
// - Bit 2 set on stop condition
// - Bit 1 set on start condition
// - Bit 0 set on valid break
// - Reading status clears every flag whose event does not arrive in the same cycle
// - Control bit 12 disables rising edge interrupt
module lss_sync_status
	import lss_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// LIN line, receive only
	input wire logic lin_rx,
	input wire logic lp_osc_tick,
	// Interrupt
	output logic irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] irq_stat;
		logic [7:0] irq_mask;
		logic [15:0] ctl;
		logic [7:0] edge_sel;
		logic [15:0] sync_cmp;
		logic [11:0] brk_cmp;
		logic urst;
		logic done;
		logic wr_pend;
		logic [31:0] wr_addr;
		logic [31:0] rd_data;
	} lss_regs_t;

	lss_regs_t s_r, s_nxt;
	logic acc, rd_clr, wr;
	logic [7:0] ev, w1c, irq_act;
	logic [31:0] rd_v;
	logic [11:0] brk_cnt;
	logic [15:0] sync_cnt;
	logic brk_hit, brk_ovf, start_p, stop_p, cmp_p, rise_p;

	// ****************************************
	// Timers
	// ****************************************
	lss_brk_timer u_brk (
		.core_clk(core_clk),
		.rst(rst),
		.lin_rx(lin_rx),
		.lp_tick(lp_osc_tick),
		.clr(s_r.urst),
		.brk_cmp(s_r.brk_cmp),
		.count(brk_cnt),
		.brk_hit(brk_hit),
		.brk_ovf(brk_ovf)
	);

	lss_sync_timer u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.lin_rx(lin_rx),
		.enable(s_r.ctl[CTL_EN]),
		.clr(s_r.urst),
		.brk_hit(brk_hit),
		.edge_rise(s_r.edge_sel[EDGE_RISE]),
		.start_sel(s_r.edge_sel[EDGE_START_LSB +: 3]),
		.stop_sel(s_r.edge_sel[EDGE_STOP_LSB +: 3]),
		.cmp_val(s_r.sync_cmp),
		.count(sync_cnt),
		.start_p(start_p),
		.stop_p(stop_p),
		.cmp_p(cmp_p),
		.rise_p(rise_p)
	);

	// ****************************************
	// Events
	// ****************************************
	always_comb
	begin
		ev = 8'h00;
		ev[ST_BRK] = brk_hit;
		ev[ST_START] = start_p;
		ev[ST_STOP] = stop_p;
		ev[ST_CMP] = cmp_p;
		ev[ST_BRK_ERR] = brk_ovf;
		ev[ST_RST_DONE] = s_r.done;
		ev[ST_RISE] = rise_p && s_r.ctl[CTL_BSM];
		ev[ST_RSVD] = 1'b0;
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb
	begin
		rd_v = 32'h0000_0000;
		case (haddr)
			ADDR_STATUS:
				rd_v = {24'h00_0000, s_r.status};
			ADDR_CTL0:
				rd_v = {16'h0000, s_r.ctl};
			ADDR_EDGE:
				rd_v = {24'h00_0000, s_r.edge_sel};
			ADDR_SYNC_VAL:
				rd_v = {16'h0000, sync_cnt};
			ADDR_BRK_VAL:
				rd_v = {20'h0_0000, brk_cnt};
			ADDR_SYNC_CMP:
				rd_v = {16'h0000, s_r.sync_cmp};
			ADDR_BRK_CMP:
				rd_v = {20'h0_0000, s_r.brk_cmp};
			ADDR_IRQ_STAT:
				rd_v = {24'h00_0000, s_r.irq_stat};
			ADDR_IRQ_MASK:
				rd_v = {24'h00_0000, s_r.irq_mask};
			default:
				rd_v = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		s_nxt = s_r;
		acc = hsel && htrans[1] && hready;
		rd_clr = acc && !hwrite && (haddr == ADDR_STATUS);
		wr = s_r.wr_pend;
		w1c = 8'h00;
		// Address phase
		s_nxt.wr_pend = acc && hwrite;
		if (acc)
			s_nxt.wr_addr = haddr;
		// Read data latched now, so no wait state is needed
		if (acc && !hwrite)
			s_nxt.rd_data = rd_v;
		// Data phase writes
		s_nxt.urst = 1'b0;
		if (wr)
		begin
			case (s_r.wr_addr)
				ADDR_CTL0:
				begin
					s_nxt.ctl = hwdata[15:0];
					s_nxt.ctl[CTL_URST] = 1'b0;
					s_nxt.urst = hwdata[CTL_URST];
				end
				ADDR_EDGE:
					s_nxt.edge_sel = hwdata[7:0];
				ADDR_SYNC_CMP:
					s_nxt.sync_cmp = hwdata[15:0];
				ADDR_BRK_CMP:
					s_nxt.brk_cmp = hwdata[11:0];
				ADDR_IRQ_STAT:
					w1c = hwdata[7:0];
				ADDR_IRQ_MASK:
					s_nxt.irq_mask = hwdata[7:0];
				// Status and timer values ignore writes
				default:
					w1c = 8'h00;
			endcase
		end
		// Done one cycle after the unit reset pulse, in the same cycle the timers read zero
		s_nxt.done = s_r.urst;
		// Set wins over the clearing read
		s_nxt.status = (rd_clr ? 8'h00 : s_r.status) | ev;
		s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;
	end

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			s_r <= '0;
			s_r.status <= STATUS_RST;
			s_r.irq_mask <= MASK_RST;
			s_r.ctl <= CTL0_RST;
			s_r.edge_sel <= EDGE_RST;
			s_r.sync_cmp <= SYNC_CMP_RST;
			s_r.brk_cmp <= BRK_CMP_RST;
		end
		else
			s_r <= s_nxt;

	// ****************************************
	// Outputs
	// ****************************************
	always_comb
	begin
		// Flag still reports the edge; only its interrupt is gated
		irq_act = s_r.irq_stat & s_r.irq_mask;
		irq_act[ST_RISE] = irq_act[ST_RISE] && !s_r.ctl[CTL_RISE_DIS];
	end

	// Zero wait states; errors never signalled
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_r.rd_data;
	assign irq = |irq_act;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	stat_rsvd_a: assert property (!s_r.status[ST_RSVD])
		else $error("reserved status bit set");

	rd_clear_a: assert property (rd_clr |=> s_r.status == $past(ev))
		else $error("status not cleared by read");

	set_wins_a: assert property (
		rd_clr && ev[ST_RST_DONE] |=> s_r.status[ST_RST_DONE])
		else $error("event lost during clearing read");

	brk_err_a: assert property (
		brk_ovf && s_r.irq_mask[ST_BRK_ERR] |=> s_r.status[ST_BRK_ERR] && irq)
		else $error("break error not flagged");

	rise_bsm_a: assert property (
		$rose(s_r.status[ST_RISE]) |-> $past(s_r.ctl[CTL_BSM]))
		else $error("rise flag outside bit-serial mode");

	rst_done_a: assert property (
		s_r.urst |-> ##2 s_r.status[ST_RST_DONE])
		else $error("reset done flag missing");

	rise_gate_a: assert property (
		s_r.ctl[CTL_RISE_DIS] && (s_r.irq_stat & s_r.irq_mask & 8'hbf) == 8'h00
		|-> !irq)
		else $error("disabled rise edge raised irq");

	cmp_flag_a: assert property (cmp_p |=> s_r.status[ST_CMP])
		else $error("compare flag missing");

	stop_flag_a: assert property (stop_p |=> s_r.status[ST_STOP])
		else $error("stop flag missing");

	start_flag_a: assert property (start_p |=> s_r.status[ST_START])
		else $error("start flag missing");

	brk_flag_a: assert property (brk_hit |=> s_r.status[ST_BRK])
		else $error("break flag missing");

	sync_run_a: assert property (
		start_p && !stop_p |-> ##[1:40] sync_cnt != 16'h0000
		or ##[1:40] (stop_p || s_r.urst || !s_r.ctl[CTL_EN]))
		else $error("sync timer not counting");

	// ****************************************
	// Bus and timer checks
	// ****************************************
	// Timers are watched at their ports only
	rd_data_a: assert property (
		rd_clr |=> hrdata == {24'h00_0000, $past(s_r.status)})
		else $error("status read data wrong");

	hrdata_hold_a: assert property (
		!(acc && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");

	flag_hold_a: assert property (
		!rd_clr && ev == 8'h00 |=> $stable(s_r.status))
		else $error("status changed without event or read");

	urst_bit_a: assert property (!s_r.ctl[CTL_URST])
		else $error("unit reset bit did not self clear");

	urst_clr_a: assert property (
		s_r.urst |=> brk_cnt == 12'h000 && sync_cnt == 16'h0000)
		else $error("unit reset left a timer running");

	brk_tick_a: assert property (
		!lp_osc_tick && !lin_rx && !s_r.urst |=> $stable(brk_cnt))
		else $error("break timer moved without a tick");

	brk_hit_val_a: assert property (
		brk_hit |-> brk_cnt == $past(s_r.brk_cmp) && !$past(lin_rx))
		else $error("break hit away from compare value");

	brk_wrap_a: assert property (
		brk_ovf |-> brk_cnt == 12'h000 && !$past(lin_rx))
		else $error("break timer did not wrap on overflow");

	irq_level_a: assert property (
		(s_r.irq_stat & s_r.irq_mask & 8'hbf) != 8'h00 |-> irq)
		else $error("pending interrupt not raised");

	w1c_a: assert property (
		s_r.wr_pend && s_r.wr_addr == ADDR_IRQ_STAT && ev == 8'h00
		|=> ({24'h00_0000, s_r.irq_stat} & $past(hwdata)) == 32'h0000_0000)
		else $error("interrupt status not cleared by write");

	sync_off_a: assert property (
		!s_r.ctl[CTL_EN] |=> !start_p && !stop_p && !cmp_p)
		else $error("sync event while disabled");

	start_zero_a: assert property (
		start_p |-> sync_cnt == 16'h0000)
		else $error("sync timer not zeroed at start");

	sync_cmp_val_a: assert property (
		cmp_p |-> sync_cnt == $past(s_r.sync_cmp))
		else $error("compare event away from compare value");

	rise_flag_a: assert property (
		s_r.ctl[CTL_BSM] && rise_p |=> s_r.status[ST_RISE])
		else $error("rise flag missing in bit-serial mode");

	brk_cov_c: cover property (brk_hit);
	sync_cov_c: cover property (start_p ##[1:1000] stop_p);
	rd_cov_c: cover property (rd_clr && |s_r.status);
	irq_cov_c: cover property (irq);
	err_cov_c: cover property (brk_ovf);

endmodule : lss_sync_status

/* tb/lss_lin_master.sv */
// LIN master node model driving the receive line and oscillator tick.
// Assumes the bench calls its tasks from one process at a time.
module lss_lin_master
#(
	parameter int TICK_DIV = 4
)
(
	// Clock
	input wire logic core_clk,
	// Line and oscillator
	output logic lin_rx,
	output logic lp_osc_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	int tick_cnt = 0;
	initial lin_rx = 1'b1;
	initial lp_osc_tick = 1'b0;
	// Free running, an oscillator never stops
	always @(posedge core_clk)
	begin
		tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
		lp_osc_tick <= (tick_cnt == TICK_DIV - 1);
	end
	task automatic drive_low(input int n);
		@(posedge core_clk);
		lin_rx <= 1'b0;
		repeat (n) @(posedge core_clk);
		lin_rx <= 1'b1;
	endtask : drive_low
	// Delimiter, start bit, 0x55 lsb first, stop; released line idles high
	task automatic sync_byte(input int bit_cyc);
		logic [9:0] frame;
		frame = {1'b1, 8'h55, 1'b0};
		repeat (bit_cyc) @(posedge core_clk);
		for (int i = 0; i < 10; i++)
		begin
			lin_rx <= frame[i];
			repeat (bit_cyc) @(posedge core_clk);
		end
		lin_rx <= 1'b1;
	endtask : sync_byte
endmodule : lss_lin_master

/* tb/tb.sv */
// Self-checking bench for the LIN sync status block.
// Assumes a single AHB-Lite master and a LIN master model on the line.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lss_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic lin_rx;
	logic lp_osc_tick;
	logic irq;
	logic [31:0] rd;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	typedef struct packed {
		logic wr;
		logic [31:0] addr;
		logic [31:0] data;
	} lss_row_t;
	localparam lss_row_t ROWS [0:10] = '{
		'{1'b0, ADDR_STATUS, 32'h0}, '{1'b0, ADDR_IRQ_MASK, 32'h10},
		'{1'b0, ADDR_EDGE, 32'h51}, '{1'b0, ADDR_CTL0, 32'h0},
		'{1'b1, ADDR_STATUS, 32'hff}, '{1'b0, ADDR_STATUS, 32'h0},
		'{1'b0, 32'hffff07f0, 32'h0}, '{1'b1, ADDR_BRK_CMP, 32'h5},
		'{1'b0, ADDR_BRK_CMP, 32'h5}, '{1'b1, ADDR_SYNC_CMP, 32'ha},
		'{1'b0, ADDR_SYNC_CMP, 32'ha}};
	always #5 core_clk = ~core_clk;
	lss_sync_status DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .lin_rx(lin_rx),
		.lp_osc_tick(lp_osc_tick), .irq(irq));
	lss_lin_master #(.TICK_DIV(4)) lin (.core_clk(core_clk),
		.lin_rx(lin_rx), .lp_osc_tick(lp_osc_tick));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Waits on hready; only the timeout ends a stuck wait
	task automatic ahb(input logic wr, input logic [31:0] addr,
		input logic [31:0] wd, output logic [31:0] r);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= addr;
		hwrite <= wr;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		r = hrdata;
	endtask : ahb
	task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
		logic [31:0] v;
		ahb(1'b0, addr, 32'h0, v);
		check(v, exp);
	endtask : rd_chk
	task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
		ahb(1'b1, addr, wd, rd);
	endtask : wr
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	// Whole run needs about 78000 cycles
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			miscompares++;
			test_done;
		end
	end
	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		foreach (ROWS[i])
		begin
			ahb(ROWS[i].wr, ROWS[i].addr, ROWS[i].data, rd);
			if (!ROWS[i].wr)
				check(rd, ROWS[i].data);
			check(32'(hresp), 32'h0);
		end
		$display("register table done");
		lin.drive_low(40);
		repeat (4) @(posedge core_clk);
		rd_chk(ADDR_STATUS, 32'h01);
		rd_chk(ADDR_STATUS, 32'h00);
		$display("break test done");
		lin.drive_low(4 * 4096 + 40);
		repeat (4) @(posedge core_clk);
		check(irq, 1'b1);
		rd_chk(ADDR_STATUS, 32'h11);
		wr(ADDR_IRQ_STAT, 32'hff);
		@(posedge core_clk);
		check(irq, 1'b0);
		$display("break error test done");
		wr(ADDR_CTL0, 32'h2);
		// This read is taken in the cycle the done event arrives
		rd_chk(ADDR_STATUS, 32'h00);
		rd_chk(ADDR_STATUS, 32'h20);
		$display("unit reset test done");
		wr(ADDR_IRQ_MASK, 32'h40);
		wr(ADDR_CTL0, 32'h4);
		lin.drive_low(3);
		repeat (3) @(posedge core_clk);
		check(irq, 1'b1);
		rd_chk(ADDR_STATUS, 32'h40);
		wr(ADDR_CTL0, 32'h1004);
		@(posedge core_clk);
		check(irq, 1'b0);
		wr(ADDR_IRQ_STAT, 32'hff);
		$display("bit-serial test done");
		wr(ADDR_EDGE, 32'h31);
		wr(ADDR_CTL0, 32'h1);
		rd_chk(ADDR_STATUS, 32'h0);
		lin.drive_low(40);
		lin.sync_byte(5000);
		rd_chk(ADDR_STATUS, 32'h0f);
		ahb(1'b0, ADDR_SYNC_VAL, 32'h0, rd);
		// Four bits of 5000 cycles at 20 cycles a count
		check(32'(rd >= 999 && rd <= 1001), 32'h1);
		$display("sync byte test done");
		wr(ADDR_EDGE, 32'hc2);
		lin.drive_low(40);
		lin.sync_byte(500);
		rd_chk(ADDR_STATUS, 32'h0f);
		ahb(1'b0, ADDR_SYNC_VAL, 32'h0, rd);
		// Rising edges 2 to 4 span four bits of 500 cycles
		check(32'(rd >= 99 && rd <= 101), 32'h1);
		$display("rising edge sync test done");
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(ADDR_CTL0, 32'h0);
		rd_chk(ADDR_EDGE, 32'h51);
		$display("reset test done");
		test_done;
	end
endmodule : tb
